//--- common/tid_pkg.sv
// Constants, register map and carrier types of the timer interrupt and DMA control block.
//
// Behaviour
// R1: Second compare-0 request before clear sets overrun
// R2: Capture interrupt is OR or AND of captures
// R3: Software sets both capture masks for AND
// R4: Global enable gates every timer interrupt
// R5: Capture-0 DMA mask cleared at block end
// R6: Compare-0 DMA mask cleared at block end
// R7: Capture-0 mask enables end-of-block interrupt under DMA
// R8: Compare-0 mask enables end-of-block interrupt under DMA
// R9: Capture-1, compare-1, wrap masks enable own interrupts
// R10: Counter pointer bit 2 toggles in compare swap
// R11: Pointer bit 1 shows active DMA channel
// R12: Counter pointer bit 0 selects memory or registers
// R13: Address pointer bit 2 toggles in compare swap
// R14: Register-file DMA ignores address pointer except swap
// R15: Segment select picks interrupt or DMA segment
// R16: Vector upper bits programmable, bit 0 zero
// R17: Vector bits 2:1 encode interrupt group
// R18: Capture-0 end-of-block set in swap, else one
// R19: Compare-0 end-of-block set in swap, else one
// R20: Capture DMA source select bit
// R21: Compare DMA destination select bit
// R22: Swap enable covers both DMA channels
// R23: Three priority level bits
// R24: Request needs flag, mask and global enable
package tid_pkg;

   // ****************************************
   // Register indices and byte addresses
   // ****************************************
   localparam logic [7:0] IDX_DMA_COUNT_POINTER = 8'hF0;
   localparam logic [7:0] IDX_DMA_ADDRESS_POINTER = 8'hF1;
   localparam logic [7:0] IDX_TIMER_VECTOR_BASE = 8'hF2;
   localparam logic [7:0] IDX_DMA_CONTROL = 8'hF3;
   localparam logic [7:0] IDX_EOB_PENDING = 8'hF4;
   localparam logic [7:0] IDX_TIMER_FLAG_REG = 8'hFE;
   localparam logic [7:0] IDX_IRQ_DMA_MASK = 8'hFF;
   localparam int ADDR_W = 10;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int FLG_CAP0 = 7;
   localparam int FLG_CAP1 = 6;
   localparam int FLG_CMP0 = 5;
   localparam int FLG_CMP1 = 4;
   localparam int FLG_WRAP = 3;
   localparam int FLG_CAP0_OVR = 2;
   localparam int FLG_CMP0_OVR = 1;
   localparam int FLG_COMBINE = 0;
   localparam int MSK_GLOBAL = 7;
   localparam int MSK_CAP0_DMA = 6;
   localparam int MSK_CAP0_IRQ = 5;
   localparam int MSK_CAP1_IRQ = 4;
   localparam int MSK_CMP0_DMA = 3;
   localparam int MSK_CMP0_IRQ = 2;
   localparam int MSK_CMP1_IRQ = 1;
   localparam int MSK_WRAP_IRQ = 0;
   localparam int CTL_CAP0_EOB = 7;
   localparam int CTL_CMP0_EOB = 6;
   localparam int CTL_CAP_SRC = 5;
   localparam int CTL_CMP_DST = 4;
   localparam int CTL_SWAP = 3;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RST_FLAG = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_CONTROL = 8'hC7;
   localparam logic [5:0] RST_PTR_HI = 6'h00;
   localparam logic [4:0] RST_VEC_HI = 5'h00;

   // ****************************************
   // Vector group codes
   // ****************************************
   typedef enum logic [1:0] {
      GRP_WRAP = 2'b00,
      GRP_UNUSED = 2'b01,
      GRP_CAPTURE = 2'b10,
      GRP_COMPARE = 2'b11
   } tid_group_type;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic cap0;
      logic cap1;
      logic cmp0;
      logic cmp1;
      logic wrap;
   } tid_evt_type;

   typedef struct packed {
      logic cap0_eob;
      logic cmp0_eob;
      logic cap0_ack;
      logic cmp0_ack;
   } tid_dma_in_type;

   typedef struct packed {
      logic [7:0] count_ptr;
      logic [7:0] addr_ptr;
      logic use_regfile;
      logic dma_segment_sel;
      logic cap0_req;
      logic cmp0_req;
   } tid_dma_out_type;

   typedef struct packed {
      logic [2:0] priority_level;
      logic capture_dma_source_sel;
      logic compare_dma_dest_sel;
      logic swap_mode_en;
   } tid_cfg_type;

endpackage : tid_pkg

//--- logic/tid_core.sv
// Interrupt and DMA request control of a multifunction timer, with APB register access.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module tid_core
   import tid_pkg::*;
#(
   parameter int PADDR_W = 12
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer datapath events, one-cycle pulses
   input wire tid_evt_type timer_evt,
   // DMA controller handshake
   input wire tid_dma_in_type dma_in,
   output tid_dma_out_type dma_out,
   // Interrupt controller side
   output logic irq_req,
   output logic [7:0] irq_vector,
   output tid_cfg_type cfg
);

   // ****************************************
   // Elaboration check
   // ****************************************
   if (PADDR_W < ADDR_W) begin : g_addr_chk
      $error("tid_core: PADDR_W must be at least 10");
   end

   localparam logic [ADDR_W-1:0] A_DCP = {IDX_DMA_COUNT_POINTER, 2'b00};
   localparam logic [ADDR_W-1:0] A_DAP = {IDX_DMA_ADDRESS_POINTER, 2'b00};
   localparam logic [ADDR_W-1:0] A_VEC = {IDX_TIMER_VECTOR_BASE, 2'b00};
   localparam logic [ADDR_W-1:0] A_CTL = {IDX_DMA_CONTROL, 2'b00};
   localparam logic [ADDR_W-1:0] A_EOB = {IDX_EOB_PENDING, 2'b00};
   localparam logic [ADDR_W-1:0] A_FLG = {IDX_TIMER_FLAG_REG, 2'b00};
   localparam logic [ADDR_W-1:0] A_MSK = {IDX_IRQ_DMA_MASK, 2'b00};

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0] timer_flag_reg;
      logic [7:0] irq_dma_mask;
      logic [5:0] dma_count_addr_hi;
      logic dma_region_regfile;
      logic [5:0] dma_addr_loc_hi;
      logic dma_segment_sel;
      logic [4:0] vec_hi;
      tid_group_type vec_grp;
      logic cap0_end_of_block;
      logic cmp0_end_of_block;
      logic capture_dma_source_sel;
      logic compare_dma_dest_sel;
      logic swap_mode_en;
      logic [2:0] priority_level;
      logic eob_pend_cap0;
      logic eob_pend_cmp0;
      logic dma_channel_id;
      logic cap0_req;
      logic cmp0_req;
      logic [7:0] addr_ptr;
      logic seg_out;
      logic irq;
      logic ready;
      logic slverr;
      logic [31:0] rdata;
   } tid_state_type;

   tid_state_type s;
   tid_state_type next_s;
   logic [1:0] rst_sync;
   logic rst_n_int;

   // ****************************************
   // Reset release
   // ****************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n_int = rst_sync[1];

   // ****************************************
   // Decode and read mux
   // ****************************************
   logic [ADDR_W-1:0] addr;
   logic hit;
   logic [7:0] rd_byte;
   logic wr_en;
   logic [7:0] wbyte;

   assign addr = paddr[ADDR_W-1:0];
   assign wr_en = psel & penable & pwrite & s.ready & hit;
   assign wbyte = pwdata[7:0];

   always_comb begin
      hit = 1'b1;
      rd_byte = 8'h00;
      if (paddr[PADDR_W-1:0] != {{(PADDR_W-ADDR_W){1'b0}}, addr}) begin
         hit = 1'b0;
      end else if (addr == A_DCP) begin
         rd_byte = {s.dma_count_addr_hi, s.dma_channel_id, s.dma_region_regfile};
      end else if (addr == A_DAP) begin
         rd_byte = {s.dma_addr_loc_hi, s.dma_channel_id, s.dma_segment_sel};
      end else if (addr == A_VEC) begin
         rd_byte = {s.vec_hi, s.vec_grp, 1'b0}; // [R16]
      end else if (addr == A_CTL) begin
         rd_byte = {s.cap0_end_of_block, s.cmp0_end_of_block, s.capture_dma_source_sel,
                    s.compare_dma_dest_sel, s.swap_mode_en, s.priority_level};
      end else if (addr == A_EOB) begin
         rd_byte = {6'h00, s.eob_pend_cmp0, s.eob_pend_cap0};
      end else if (addr == A_FLG) begin
         rd_byte = s.timer_flag_reg;
      end else if (addr == A_MSK) begin
         rd_byte = s.irq_dma_mask;
      end else begin
         hit = 1'b0;
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   logic cap0_dma_on;
   logic cmp0_dma_on;
   logic cap0_src;
   logic cap1_src;
   logic cmp0_src;
   logic cmp1_src;
   logic wrap_src;
   logic cap_int;
   logic cmp_int;

   assign cap0_dma_on = s.irq_dma_mask[MSK_CAP0_DMA];
   assign cmp0_dma_on = s.irq_dma_mask[MSK_CMP0_DMA];

   always_comb begin
      next_s = s;

      // Interrupt sources; end-of-block pending outlives the DMA mask clear
      cap0_src = (s.eob_pend_cap0 | (~cap0_dma_on & s.timer_flag_reg[FLG_CAP0]))
                 & s.irq_dma_mask[MSK_CAP0_IRQ]; // [R7]
      cap1_src = s.timer_flag_reg[FLG_CAP1] & s.irq_dma_mask[MSK_CAP1_IRQ]; // [R9]
      cmp0_src = (s.eob_pend_cmp0 | (~cmp0_dma_on & s.timer_flag_reg[FLG_CMP0]))
                 & s.irq_dma_mask[MSK_CMP0_IRQ]; // [R8]
      cmp1_src = s.timer_flag_reg[FLG_CMP1] & s.irq_dma_mask[MSK_CMP1_IRQ]; // [R9]
      wrap_src = s.timer_flag_reg[FLG_WRAP] & s.irq_dma_mask[MSK_WRAP_IRQ]; // [R9]
      if (s.timer_flag_reg[FLG_COMBINE]) begin
         cap_int = cap0_src & cap1_src; // [R2] [R3]
      end else begin
         cap_int = cap0_src | cap1_src; // [R2]
      end
      cmp_int = cmp0_src | cmp1_src;

      // Software writes
      if (wr_en) begin
         if (addr == A_DCP) begin
            next_s.dma_count_addr_hi = wbyte[7:2];
            next_s.dma_region_regfile = wbyte[0]; // [R12]
         end else if (addr == A_DAP) begin
            next_s.dma_addr_loc_hi = wbyte[7:2];
            next_s.dma_segment_sel = wbyte[0];
         end else if (addr == A_VEC) begin
            next_s.vec_hi = wbyte[7:3]; // [R16]
         end else if (addr == A_CTL) begin
            next_s.cap0_end_of_block = wbyte[CTL_CAP0_EOB];
            next_s.cmp0_end_of_block = wbyte[CTL_CMP0_EOB];
            next_s.capture_dma_source_sel = wbyte[CTL_CAP_SRC]; // [R20]
            next_s.compare_dma_dest_sel = wbyte[CTL_CMP_DST]; // [R21]
            next_s.swap_mode_en = wbyte[CTL_SWAP]; // [R22]
            next_s.priority_level = wbyte[2:0]; // [R23]
         end else if (addr == A_EOB) begin
            next_s.eob_pend_cap0 = wbyte[0];
            next_s.eob_pend_cmp0 = wbyte[1];
         end else if (addr == A_FLG) begin
            next_s.timer_flag_reg = wbyte;
         end else if (addr == A_MSK) begin
            next_s.irq_dma_mask = wbyte;
         end
      end

      // Capture 0: DMA request or flag, overrun on a second request
      if (timer_evt.cap0) begin
         if (cap0_dma_on) begin
            if (s.cap0_req) begin
               next_s.timer_flag_reg[FLG_CAP0_OVR] = 1'b1;
            end
            next_s.cap0_req = 1'b1;
            next_s.dma_channel_id = 1'b0; // [R11]
         end else begin
            if (next_s.timer_flag_reg[FLG_CAP0]) begin
               next_s.timer_flag_reg[FLG_CAP0_OVR] = 1'b1;
            end
            next_s.timer_flag_reg[FLG_CAP0] = 1'b1;
         end
      end

      // Compare 0: overrun when the previous request is still pending
      if (timer_evt.cmp0) begin
         if (cmp0_dma_on) begin
            if (s.cmp0_req) begin
               next_s.timer_flag_reg[FLG_CMP0_OVR] = 1'b1; // [R1]
            end
            next_s.cmp0_req = 1'b1;
            next_s.dma_channel_id = 1'b1; // [R11]
         end else begin
            if (next_s.timer_flag_reg[FLG_CMP0]) begin
               next_s.timer_flag_reg[FLG_CMP0_OVR] = 1'b1; // [R1]
            end
            next_s.timer_flag_reg[FLG_CMP0] = 1'b1;
         end
      end

      if (timer_evt.cap1) begin
         next_s.timer_flag_reg[FLG_CAP1] = 1'b1;
      end
      if (timer_evt.cmp1) begin
         next_s.timer_flag_reg[FLG_CMP1] = 1'b1;
      end
      if (timer_evt.wrap) begin
         next_s.timer_flag_reg[FLG_WRAP] = 1'b1;
      end

      // DMA acknowledges drop the requests
      if (dma_in.cap0_ack && !(timer_evt.cap0 && cap0_dma_on)) begin
         next_s.cap0_req = 1'b0;
      end
      if (dma_in.cmp0_ack && !(timer_evt.cmp0 && cmp0_dma_on)) begin
         next_s.cmp0_req = 1'b0;
      end

      // End of block: hardware clears DMA mask, raises pending interrupt
      if (dma_in.cap0_eob) begin
         next_s.irq_dma_mask[MSK_CAP0_DMA] = 1'b0; // [R5]
         next_s.eob_pend_cap0 = 1'b1; // [R7]
         if (s.swap_mode_en) begin
            next_s.cap0_end_of_block = 1'b1; // [R18]
         end
      end
      if (dma_in.cmp0_eob) begin
         next_s.irq_dma_mask[MSK_CMP0_DMA] = 1'b0; // [R6]
         next_s.eob_pend_cmp0 = 1'b1; // [R8]
         if (s.swap_mode_en) begin
            next_s.cmp0_end_of_block = 1'b1; // [R19]
            next_s.dma_count_addr_hi[0] = ~s.dma_count_addr_hi[0]; // [R10]
            next_s.dma_addr_loc_hi[0] = ~s.dma_addr_loc_hi[0]; // [R13]
         end
      end

      // End-of-block bits held at one outside swap mode
      if (!next_s.swap_mode_en) begin
         next_s.cap0_end_of_block = 1'b1; // [R18]
         next_s.cmp0_end_of_block = 1'b1; // [R19]
      end

      // Interrupt request and vector group
      next_s.irq = s.irq_dma_mask[MSK_GLOBAL] & (cap_int | cmp_int | wrap_src); // [R4] [R24]
      if (cap_int) begin
         next_s.vec_grp = GRP_CAPTURE; // [R17]
      end else if (cmp_int) begin
         next_s.vec_grp = GRP_COMPARE; // [R17]
      end else if (wrap_src) begin
         next_s.vec_grp = GRP_WRAP; // [R17]
      end

      // Pointer outputs registered from the next values
      if (next_s.dma_region_regfile) begin
         next_s.addr_ptr = {5'h00, next_s.swap_mode_en & next_s.dma_addr_loc_hi[0], 2'b00}; // [R14]
      end else begin
         next_s.addr_ptr = {next_s.dma_addr_loc_hi, next_s.dma_channel_id, next_s.dma_segment_sel};
      end
      next_s.seg_out = ~next_s.dma_region_regfile & next_s.dma_segment_sel; // [R15]

      // APB: no wait state, answer prepared in the setup cycle
      next_s.ready = 1'b0;
      next_s.slverr = 1'b0;
      if (psel && !penable && !s.ready) begin
         next_s.ready = 1'b1;
         next_s.slverr = ~hit;
         next_s.rdata = {24'h000000, rd_byte};
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge ref_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         s <= '0;
         s.timer_flag_reg <= RST_FLAG;
         s.irq_dma_mask <= RST_MASK;
         s.dma_count_addr_hi <= RST_PTR_HI;
         s.dma_addr_loc_hi <= RST_PTR_HI;
         s.vec_hi <= RST_VEC_HI;
         s.vec_grp <= GRP_WRAP;
         s.cap0_end_of_block <= RST_CONTROL[CTL_CAP0_EOB];
         s.cmp0_end_of_block <= RST_CONTROL[CTL_CMP0_EOB];
         s.capture_dma_source_sel <= RST_CONTROL[CTL_CAP_SRC];
         s.compare_dma_dest_sel <= RST_CONTROL[CTL_CMP_DST];
         s.swap_mode_en <= RST_CONTROL[CTL_SWAP];
         s.priority_level <= RST_CONTROL[2:0];
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.slverr;
   assign irq_req = s.irq;
   assign irq_vector = {s.vec_hi, s.vec_grp, 1'b0}; // [R16] [R17]
   assign cfg.priority_level = s.priority_level;
   assign cfg.capture_dma_source_sel = s.capture_dma_source_sel;
   assign cfg.compare_dma_dest_sel = s.compare_dma_dest_sel;
   assign cfg.swap_mode_en = s.swap_mode_en;
   assign dma_out.count_ptr = {s.dma_count_addr_hi, s.dma_channel_id, s.dma_region_regfile};
   assign dma_out.addr_ptr = s.addr_ptr; // [R14]
   assign dma_out.use_regfile = s.dma_region_regfile; // [R12]
   assign dma_out.dma_segment_sel = s.seg_out; // [R15]
   assign dma_out.cap0_req = s.cap0_req;
   assign dma_out.cmp0_req = s.cmp0_req;

endmodule : tid_core

//--- tb/tid_core_chk.sv
// Concurrent checks on the ports of the timer interrupt and DMA control block.
`timescale 1ns/1ps
module tid_core_chk
   import tid_pkg::*;
#(
   parameter int PADDR_W = 12
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Timer, DMA and interrupt side
   input wire tid_evt_type timer_evt,
   input wire tid_dma_in_type dma_in,
   input wire tid_dma_out_type dma_out,
   input wire logic irq_req,
   input wire logic [7:0] irq_vector,
   input wire tid_cfg_type cfg
);
   logic wr;
   logic [7:0] msk;
   logic [5:0] ctl;
   assign wr = psel && penable && pready && pwrite && clk_en && !pslverr;
   // Software copy of mask and control bits
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         msk <= 8'h00;
         ctl <= 6'h07;
      end else begin
         if (wr && paddr == PADDR_W'({IDX_IRQ_DMA_MASK, 2'b00})) msk <= pwdata[7:0];
         if (wr && paddr == PADDR_W'({IDX_DMA_CONTROL, 2'b00})) ctl <= pwdata[5:0];
      end
   end
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   sequence s_setup;
      psel && !penable && clk_en;
   endsequence
   sequence s_answer;
      psel && penable && pready;
   endsequence
   AST_APB_ANSWER: assert property (s_setup |=> s_answer)
      else $error("no answer in the first access cycle");
   AST_APB_PULSE: assert property (pready |=> !pready)
      else $error("ready stood longer than one cycle");
   AST_RDATA_HI: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   AST_VEC_FORM: assert property (irq_vector[0] == 1'b0 && irq_vector[2:1] != 2'b01)
      else $error("vector low bits malformed");
   AST_GLOBAL_GATE: assert property (!msk[7] [*2] |-> !irq_req)
      else $error("interrupt while global enable off");
   AST_IRQ_ON: assert property (clk_en && timer_evt.wrap && msk[7] && msk[0] && !wr |-> ##2 irq_req)
      else $error("wrap interrupt not raised");
   AST_CFG_MIRROR: assert property (cfg == {ctl[2:0], ctl[5:3]})
      else $error("configuration outputs differ from control");
   AST_ACK_DROP: assert property (clk_en && dma_in.cmp0_ack && !timer_evt.cmp0 |=> !dma_out.cmp0_req)
      else $error("request kept after acknowledge");
   AST_CHAN_CMP: assert property ($rose(dma_out.cmp0_req) && !dma_out.cap0_req |-> ##[0:1] dma_out.count_ptr[1])
      else $error("channel bit not set for compare");
   AST_REGFILE: assert property (dma_out.use_regfile == dma_out.count_ptr[0] &&
      (!dma_out.use_regfile || {dma_out.addr_ptr[7:3], dma_out.addr_ptr[1:0]} == 7'h00))
      else $error("register file pointer form wrong");
   AST_SEG: assert property (!dma_out.use_regfile |-> dma_out.dma_segment_sel == dma_out.addr_ptr[0])
      else $error("segment select differs from pointer");
endmodule : tid_core_chk

bind tid_core tid_core_chk #(.PADDR_W(PADDR_W)) u_chk (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timer_evt(timer_evt), .dma_in(dma_in), .dma_out(dma_out),
   .irq_req(irq_req), .irq_vector(irq_vector), .cfg(cfg));

//--- tb/tid_core_tb.sv
// Self-checking testbench of the timer interrupt and DMA control block.
`timescale 1ns/1ps
module tid_core_tb
   import tid_pkg::*;
;
   typedef struct packed {logic [7:0] exp; logic [7:0] msk; logic err;} tid_note_type;
   localparam int BLK = 3;
   localparam logic [7:0] SRC_MSK [5] = '{8'h20, 8'h10, 8'h04, 8'h02, 8'h01};
   localparam logic [1:0] SRC_GRP [5] = '{2'b10, 2'b10, 2'b11, 2'b11, 2'b00};
   logic ref_clk, rstn, clk_en, psel, penable, pwrite, pready, pslverr, irq_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] irq_vector;
   logic [4:0] vhi;
   tid_evt_type timer_evt;
   tid_dma_in_type dma_in;
   tid_dma_out_type dma_out;
   tid_cfg_type cfg;
   tid_note_type notes [$];
   int error_cnt, samples_checked, cyc;
   tid_core #(.PADDR_W(12)) u_dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_evt(timer_evt), .dma_in(dma_in), .dma_out(dma_out), .irq_req(irq_req),
      .irq_vector(irq_vector), .cfg(cfg));
   tid_dma_host #(.BLK(BLK)) u_host (.ref_clk(ref_clk), .rstn(rstn), .dma_out(dma_out), .dma_in(dma_in));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic fail(input string m);
      error_cnt++;
      $display("CHECK FAILED t=%0t %s", $time, m);
   endtask : fail
   task automatic cmp_rd(input tid_note_type n);
      samples_checked++;
      if (pslverr !== n.err || (prdata[7:0] & n.msk) !== (n.exp & n.msk)) fail("register answer");
   endtask : cmp_rd
   task automatic chk_irq(input logic e, input logic [1:0] g = 2'b00);
      samples_checked++;
      if (irq_req !== e || (e && irq_vector !== {vhi, g, 1'b0})) fail("interrupt output");
   endtask : chk_irq
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [7:0] x,
      input logic [7:0] m, input logic err);
      notes.push_back('{x, m, err});
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'($urandom()), d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic err = 1'b0);
      apb(1'b1, idx, d, 8'h00, 8'h00, err);
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [7:0] x, input logic [7:0] m = 8'hFF, input logic err = 1'b0);
      apb(1'b0, idx, 8'h00, x, m, err);
   endtask : rd
   task automatic settle();
      repeat (2) @(posedge ref_clk);
   endtask : settle
   task automatic pulse(input tid_evt_type e);
      @(posedge ref_clk);
      timer_evt <= e;
      @(posedge ref_clk);
      timer_evt <= '0;
   endtask : pulse
   task automatic dma_run(input tid_evt_type e);
      repeat (BLK) begin
         pulse(e);
         do begin
            @(posedge ref_clk);
         end while ((dma_out.cap0_req | dma_out.cmp0_req) !== 1'b0);
      end
      settle();
   endtask : dma_run
   task automatic conclude();
      if (notes.size() != 0) fail("register answer missing");
      $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'b1) begin
         if (notes.size() == 0) fail("answer without request");
         else cmp_rd(notes.pop_front());
      end
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail("timeout");
         conclude();
      end
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [31:0] r;
      {rstn, psel, penable, pwrite, paddr, pwdata, timer_evt, vhi} = '0;
      clk_en = 1'b1;
      {error_cnt, samples_checked, cyc} = '0;
      r = $urandom(32'hA4FD2D89);
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(IDX_DMA_CONTROL, 8'hC7);
      rd(IDX_IRQ_DMA_MASK, 8'h00);
      rd(IDX_TIMER_FLAG_REG, 8'h00);
      wr(8'h10, 8'h5A, 1'b1);
      rd(8'h10, 8'h00, 8'hFF, 1'b1);
      r = $urandom();
      vhi = r[7:3];
      wr(IDX_TIMER_VECTOR_BASE, r[7:0]);
      rd(IDX_TIMER_VECTOR_BASE, {vhi, 3'b000}, 8'hF9);
      for (int i = 0; i < 5; i++) begin
         wr(IDX_IRQ_DMA_MASK, 8'h80);
         pulse(tid_evt_type'(5'h10 >> i));
         settle();
         chk_irq(1'b0);
         wr(IDX_IRQ_DMA_MASK, SRC_MSK[i]);
         settle();
         chk_irq(1'b0);
         wr(IDX_IRQ_DMA_MASK, 8'h80 | SRC_MSK[i]);
         settle();
         chk_irq(1'b1, SRC_GRP[i]);
         wr(IDX_TIMER_FLAG_REG, 8'h00);
         settle();
         chk_irq(1'b0);
      end
      wr(IDX_TIMER_FLAG_REG, 8'h01);
      wr(IDX_IRQ_DMA_MASK, 8'hB0);
      pulse(tid_evt_type'(5'h10));
      settle();
      chk_irq(1'b0);
      pulse(tid_evt_type'(5'h08));
      settle();
      chk_irq(1'b1, 2'b10);
      wr(IDX_TIMER_FLAG_REG, 8'h00);
      wr(IDX_IRQ_DMA_MASK, 8'h81);
      pulse(tid_evt_type'(5'h01));
      settle();
      chk_irq(1'b1, 2'b00);
      wr(IDX_IRQ_DMA_MASK, 8'h00);
      wr(IDX_TIMER_FLAG_REG, 8'h00);
      pulse(tid_evt_type'(5'h04));
      rd(IDX_TIMER_FLAG_REG, 8'h20);
      pulse(tid_evt_type'(5'h04));
      rd(IDX_TIMER_FLAG_REG, 8'h22);
      wr(IDX_TIMER_FLAG_REG, 8'h20);
      rd(IDX_TIMER_FLAG_REG, 8'h20);
      wr(IDX_TIMER_FLAG_REG, 8'h00);
      wr(IDX_DMA_COUNT_POINTER, 8'hA4);
      wr(IDX_DMA_ADDRESS_POINTER, 8'h5C);
      wr(IDX_DMA_CONTROL, 8'h0D);
      wr(IDX_IRQ_DMA_MASK, 8'h8C);
      dma_run(tid_evt_type'(5'h04));
      chk_irq(1'b1, 2'b11);
      rd(IDX_IRQ_DMA_MASK, 8'h84);
      rd(IDX_DMA_CONTROL, 8'h4D, 8'h7F);
      rd(IDX_DMA_COUNT_POINTER, 8'hA2);
      rd(IDX_DMA_ADDRESS_POINTER, 8'h5A);
      wr(IDX_EOB_PENDING, 8'h00);
      settle();
      chk_irq(1'b0);
      wr(IDX_IRQ_DMA_MASK, 8'hE0);
      dma_run(tid_evt_type'(5'h10));
      chk_irq(1'b1, 2'b10);
      rd(IDX_IRQ_DMA_MASK, 8'hA0);
      rd(IDX_DMA_CONTROL, 8'hCD);
      rd(IDX_DMA_COUNT_POINTER, 8'hA0);
      wr(IDX_EOB_PENDING, 8'h00);
      wr(IDX_DMA_CONTROL, 8'h00);
      rd(IDX_DMA_CONTROL, 8'hC0);
      r = $urandom();
      wr(IDX_DMA_CONTROL, {2'b00, r[5:0]});
      rd(IDX_DMA_CONTROL, {2'b00, r[5:0]}, 8'h3F);
      wr(IDX_DMA_COUNT_POINTER, 8'hA7);
      rd(IDX_DMA_COUNT_POINTER, 8'hA5);
      settle();
      conclude();
   end
endmodule : tid_core_tb

//--- tb/tid_dma_host.sv
// Model of the DMA controller that serves the block's two DMA channels.
`timescale 1ns/1ps
module tid_dma_host
   import tid_pkg::*;
#(
   parameter int BLK = 3
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // DMA handshake
   input wire tid_dma_out_type dma_out,
   output tid_dma_in_type dma_in
);
   logic [1:0] ack_q;
   logic [1:0] eob_q;
   logic [1:0] busy;
   logic [1:0] req;
   int wait_c [2];
   int done_c [2];
   assign req = {dma_out.cap0_req, dma_out.cmp0_req};
   assign dma_in = {eob_q, ack_q};
   // Acknowledge after a random delay, end of block on the last transfer
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 2'b00;
         eob_q <= 2'b00;
         busy <= 2'b00;
         wait_c <= '{0, 0};
         done_c <= '{0, 0};
      end else begin
         ack_q <= 2'b00;
         eob_q <= 2'b00;
         for (int i = 0; i < 2; i++) begin
            if (!req[i]) begin
               busy[i] <= 1'b0;
               wait_c[i] <= $urandom_range(3, 0);
            end else if (!busy[i] && wait_c[i] > 0) begin
               wait_c[i] <= wait_c[i] - 1;
            end else if (!busy[i]) begin
               busy[i] <= 1'b1;
               ack_q[i] <= 1'b1;
               done_c[i] <= (done_c[i] + 1) % BLK;
               eob_q[i] <= (done_c[i] == BLK - 1);
            end
         end
      end
   end
endmodule : tid_dma_host
